//--- rtl/dlp_periph.sv
/*
  peripheral end: parses packets, corrects headers, returns one
  packet per transmission.
  assumes the user supplies exactly the counted return payload bytes.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - every byte travels lsb first
// - count and checksum go low byte first
// - long packet: header, payload, checksum footer
// - header order: id, count, correction byte
// - long packet spans 6 to 65541 bytes
// - count covers payload bytes only
// - receiver takes exactly counted bytes, no codes
// - host always computes payload checksum
// - empty payload checksum equals all ones
// - uncomputed checksum footer sends two zeros
// - payload is whole bytes
// - short packet: id, two bytes, correction
// - header: fix single, detect double errors
// - id byte: tag high two, type low six
// - type decides short or long length
// - after packet end expect header or end
// - host always sends header correction byte
// - peripheral corrects forward, protects reverse headers
// - packets may carry differing channel tags
// - act only on own channel tag; a double-error header still raises hd_vld and hd_bad for any tag
// - returned packets carry own channel tag
// - one answer-seeking packet per transmission
// - short is four bytes, count spans 16 bits
module dlp_periph
  import dlp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // link
  dlp_link_if.periph       lnk,
  // own channel tag
  input  wire logic [1:0]  my_tag,
  // received header
  output logic             hd_vld,
  output logic [7:0]       hd_id,
  output logic [15:0]      hd_word,
  output logic             hd_corr,
  output logic             hd_bad,
  // received payload
  output logic             pd_vld,
  output logic [7:0]       pd_data,
  output logic             pd_last,
  // received footer check
  output logic             ck_vld,
  output logic             ck_bad,
  // return packet request
  input  wire logic        tq_vld,
  output logic             tq_rdy,
  input  wire logic [5:0]  tq_type,
  input  wire logic [15:0] tq_word,
  // return payload bytes
  input  wire logic        tp_vld,
  output logic             tp_rdy,
  input  wire logic [7:0]  tp_data
);

  typedef enum logic [1:0] {
    R_HDR  = 2'b00,
    R_PAY  = 2'b01,
    R_FTR  = 2'b11,
    R_DROP = 2'b10
  } dlp_rxs_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_HDR  = 3'b001,
    T_PAY  = 3'b011,
    T_FTR  = 3'b010,
    T_END  = 3'b110
  } dlp_txs_t;

  typedef struct packed {
    // receive side
    dlp_rxs_t    rs;
    logic [2:0]  rb;
    logic [7:0]  rsh;
    logic [15:0] ri;
    logic [23:0] rh;
    logic [15:0] rn;
    logic [15:0] rc;
    logic [7:0]  rf;
    logic        mine;
    logic        hd_vld;
    logic [7:0]  hd_id;
    logic [15:0] hd_word;
    logic        hd_corr;
    logic        hd_bad;
    logic        pd_vld;
    logic [7:0]  pd_data;
    logic        pd_last;
    logic        ck_vld;
    logic        ck_bad;
    // return side
    dlp_txs_t    ts;
    logic        tq_rdy;
    logic        tok;
    logic [2:0]  tb;
    logic [7:0]  tcur;
    logic [15:0] ti;
    logic [31:0] th;
    logic        tlong;
    logic [15:0] tn;
    logic        frm;
    logic        vld;
    logic        bt;
  } dlp_dev_st_t;

  dlp_dev_st_t s_r;
  dlp_dev_st_t s_nxt;
  logic [7:0]  rxb;
  logic [7:0]  chk;
  logic [4:0]  syn;
  logic        ovp;
  logic [23:0] hfix;
  logic [15:0] ftr;
  logic [23:0] th24;
  logic        fvld;
  logic        fpop;
  logic [7:0]  fdat;

  // return payload is buffered so a late fetch between bits loses no byte
  dlp_fifo2 u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .in_vld   (tp_vld),
    .in_rdy   (tp_rdy),
    .in_data  (tp_data),
    .out_vld  (fvld),
    .out_rdy  (fpop),
    .out_data (fdat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive: header, counted payload, footer
  always_comb begin
    s_nxt = s_r;
    s_nxt.hd_vld = 1'b0;
    s_nxt.pd_vld = 1'b0;
    s_nxt.ck_vld = 1'b0;
    s_nxt.vld = 1'b0;
    fpop = 1'b0;
    rxb = {lnk.f_bit, s_r.rsh[7:1]};
    chk = dlp_ecc(s_r.rh);
    syn = chk[4:0] ^ rxb[4:0];
    ovp = ^{s_r.rh, rxb[DLP_ECC_OVP:0]};
    hfix = ovp ? dlp_fix(s_r.rh, syn) : s_r.rh;
    ftr = {rxb, s_r.rf};
    th24 = {tq_word, my_tag, tq_type};
    if (!lnk.f_frm) begin
      // frame gone: next is a header
      s_nxt.rs = R_HDR;
      s_nxt.rb = 3'h0;
      s_nxt.ri = 16'h0;
    end else if (lnk.f_vld) begin
      s_nxt.rsh = rxb;
      s_nxt.rb = s_r.rb + 3'h1;
      if (s_r.rb == 3'h7) begin
        unique case (s_r.rs)
          R_HDR: begin
            if (s_r.ri != 16'(DLP_HDR_BYTES - 1)) begin
              s_nxt.rh = {rxb, s_r.rh[23:8]};
              s_nxt.ri = s_r.ri + 16'h1;
            end else begin
              s_nxt.ri = 16'h0;
              s_nxt.rc = DLP_CRC_SEED;
              s_nxt.rn = hfix[23:8];
              s_nxt.mine = (hfix[7:DLP_VC_LSB] == my_tag);
              if (!ovp && (syn != 5'h00)) begin
                // double error: length unknown, drop the frame
                s_nxt.rs = R_DROP;
                s_nxt.hd_vld = 1'b1;
                s_nxt.hd_bad = 1'b1;
                s_nxt.hd_id = s_r.rh[7:0];
                s_nxt.hd_word = s_r.rh[23:8];
                s_nxt.hd_corr = 1'b0;
              end else begin
                s_nxt.hd_vld = (hfix[7:DLP_VC_LSB] == my_tag);
                s_nxt.hd_bad = 1'b0;
                s_nxt.hd_corr = ovp;
                s_nxt.hd_id = hfix[7:0];
                s_nxt.hd_word = hfix[23:8];
                if (!dlp_is_long(hfix[5:0])) s_nxt.rs = R_HDR;
                else if (hfix[23:8] == 16'h0) s_nxt.rs = R_FTR;
                else s_nxt.rs = R_PAY;
              end
            end
          end
          R_PAY: begin
            // any byte value is data here
            s_nxt.pd_vld = s_r.mine;
            s_nxt.pd_data = rxb;
            s_nxt.pd_last = (s_r.ri == s_r.rn - 16'h1);
            s_nxt.rc = dlp_crc(s_r.rc, rxb);
            s_nxt.ri = s_r.ri + 16'h1;
            if (s_r.ri == s_r.rn - 16'h1) begin
              s_nxt.ri = 16'h0;
              s_nxt.rs = R_FTR;
            end
          end
          R_FTR: begin
            if (s_r.ri == 16'h0) begin
              s_nxt.rf = rxb;
              s_nxt.ri = 16'h1;
            end else begin
              // zero footer: checksum skipped
              s_nxt.ck_vld = s_r.mine;
              s_nxt.ck_bad = (ftr != s_r.rc) && (ftr != DLP_FTR_NONE);
              s_nxt.ri = 16'h0;
              s_nxt.rs = R_HDR;
            end
          end
          R_DROP: s_nxt.rs = R_DROP;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // return: one idle cycle between bytes
    if (s_r.tok) begin
      s_nxt.vld = 1'b1;
      s_nxt.bt = s_r.tcur[s_r.tb];
      s_nxt.tb = s_r.tb + 3'h1;
      if (s_r.tb == 3'h7) s_nxt.tok = 1'b0;
    end else begin
      unique case (s_r.ts)
        T_IDLE: begin
          s_nxt.tq_rdy = 1'b1;
          if (tq_vld && s_r.tq_rdy) begin
            s_nxt.tq_rdy = 1'b0;
            s_nxt.th = {dlp_ecc(th24), th24};
            s_nxt.tlong = dlp_is_long(tq_type);
            s_nxt.tn = tq_word;
            s_nxt.ti = 16'h0;
            s_nxt.frm = 1'b1;
            s_nxt.ts = T_HDR;
          end
        end
        T_HDR: begin
          s_nxt.tcur = s_r.th[7:0];
          s_nxt.th = s_r.th >> 8;
          s_nxt.tok = 1'b1;
          s_nxt.ti = s_r.ti + 16'h1;
          if (s_r.ti == 16'(DLP_HDR_BYTES - 1)) begin
            s_nxt.ti = 16'h0;
            if (!s_r.tlong) s_nxt.ts = T_END;
            else if (s_r.tn == 16'h0) s_nxt.ts = T_FTR;
            else s_nxt.ts = T_PAY;
          end
        end
        T_PAY: begin
          if (fvld) begin
            fpop = 1'b1;
            s_nxt.tcur = fdat;
            s_nxt.tok = 1'b1;
            s_nxt.ti = s_r.ti + 16'h1;
            if (s_r.ti == s_r.tn - 16'h1) begin
              s_nxt.ti = 16'h0;
              s_nxt.ts = T_FTR;
            end
          end
        end
        T_FTR: begin
          s_nxt.tcur = DLP_FTR_NONE[7:0];
          s_nxt.tok = 1'b1;
          s_nxt.ti = s_r.ti + 16'h1;
          if (s_r.ti == 16'(DLP_FTR_BYTES - 1)) s_nxt.ts = T_END;
        end
        T_END: begin
          s_nxt.frm = 1'b0;
          s_nxt.ts = T_IDLE;
        end
        default: s_nxt.ts = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s_r <= '0;
    else s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign lnk.r_frm = s_r.frm;
  assign lnk.r_vld = s_r.vld;
  assign lnk.r_bit = s_r.bt;
  assign hd_vld    = s_r.hd_vld;
  assign hd_id     = s_r.hd_id;
  assign hd_word   = s_r.hd_word;
  assign hd_corr   = s_r.hd_corr;
  assign hd_bad    = s_r.hd_bad;
  assign pd_vld    = s_r.pd_vld;
  assign pd_data   = s_r.pd_data;
  assign pd_last   = s_r.pd_last;
  assign ck_vld    = s_r.ck_vld;
  assign ck_bad    = s_r.ck_bad;
  assign tq_rdy    = s_r.tq_rdy;

endmodule
`default_nettype wire

//--- rtl/dlp_pkg.sv
/*
  constants and coding functions of the packet layer.
  assumes both ends share one clock.
*/
package dlp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // packet layout
  localparam int          DLP_HDR_BYTES = 4;
  localparam int          DLP_FTR_BYTES = 2;
  localparam int          DLP_VC_LSB    = 6;
  localparam int          DLP_ECC_OVP   = 5;
  localparam logic [15:0] DLP_CRC_SEED  = 16'hffff;
  localparam logic [15:0] DLP_FTR_NONE  = 16'h0000;
  localparam logic [15:0] DLP_CRC_POLY  = 16'h8408;

  // packet types that ask the peripheral for an answer, then the long type range
  localparam logic [5:0]  DLP_RD_GEN0   = 6'h04;
  localparam logic [5:0]  DLP_RD_GEN1   = 6'h14;
  localparam logic [5:0]  DLP_RD_GEN2   = 6'h24;
  localparam logic [5:0]  DLP_RD_CMD0   = 6'h06;
  localparam logic [3:0]  DLP_LONG_LO   = 4'h9;
  localparam logic [3:0]  DLP_LONG_HI   = 4'he;

  ////////////////////////////////////////////////////////////////////////////
  // header: extended hamming plus overall parity

  // column of data bit idx: idx-th non-power of two
  function automatic logic [4:0] dlp_hcode(input int idx);
    int         k;
    logic [4:0] c;
    k = 0;
    c = 5'h00;
    for (int v = 3; v < 32; v++) begin
      if ((v & (v - 1)) != 0) begin
        if (k == idx) c = 5'(v);
        k++;
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] dlp_ecc(input logic [23:0] h);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (h[i]) p = p ^ dlp_hcode(i);
    end
    return {2'b00, ^{h, p}, p};
  endfunction

  // a check-bit hit flips nothing
  function automatic logic [23:0] dlp_fix(input logic [23:0] h, input logic [4:0] s);
    logic [23:0] r;
    r = h;
    for (int i = 0; i < 24; i++) begin
      if (dlp_hcode(i) == s) r[i] = ~r[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // checksum, lsb first; empty payload gives all ones
  function automatic logic [15:0] dlp_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) r = (r >> 1) ^ DLP_CRC_POLY;
      else r = r >> 1;
    end
    return r;
  endfunction

  function automatic logic dlp_is_long(input logic [5:0] t);
    return (t[3:0] >= DLP_LONG_LO) && (t[3:0] <= DLP_LONG_HI);
  endfunction

  function automatic logic dlp_needs_resp(input logic [5:0] t);
    return (t == DLP_RD_GEN0) || (t == DLP_RD_GEN1) || (t == DLP_RD_GEN2) || (t == DLP_RD_CMD0);
  endfunction

endpackage

//--- rtl/dlp_link_if.sv
/*
  serial packet link between host transmitter and display peripheral.
  assumes both ends run on the same clock; frame marks one transmission,
  vld marks one bit time.
*/
`timescale 1ns/1ps
`default_nettype none
interface dlp_link_if;
  logic f_frm;
  logic f_vld;
  logic f_bit;
  logic r_frm;
  logic r_vld;
  logic r_bit;

  modport host (output f_frm, output f_vld, output f_bit, input r_frm, input r_vld, input r_bit);
  modport periph (input f_frm, input f_vld, input f_bit, output r_frm, output r_vld, output r_bit);
endinterface
`default_nettype wire

//--- rtl/dlp_fifo2.sv
/*
  two-entry byte buffer, valid and ready both sides.
  assumes one clock; in_rdy and out_vld are flops.
*/
`timescale 1ns/1ps
`default_nettype none
module dlp_fifo2
  import dlp_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_vld,
  output logic              in_rdy,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_vld,
  input  wire logic         out_rdy,
  output logic [W-1:0]      out_data
);

  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
    logic                ir;
    logic                ov;
  } dlp_fifo_st_t;

  dlp_fifo_st_t s_r;
  dlp_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  always_comb begin
    s_nxt = s_r;
    push  = in_vld && s_r.ir;
    pop   = out_rdy && s_r.ov;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == PW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) s_nxt.rp = (s_r.rp == PW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    s_nxt.cnt = s_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    // ready drops only when full, so a stall loses no byte
    s_nxt.ir = (s_nxt.cnt != (PW + 1)'(D));
    s_nxt.ov = (s_nxt.cnt != '0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r    <= '0;
      s_r.ir <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_rdy   = s_r.ir;
  assign out_vld  = s_r.ov;
  assign out_data = s_r.mem[s_r.rp];

endmodule
`default_nettype wire

//--- rtl/dlp_host.sv
/*
  host end: packs commands and payload into packets sent lsb first,
  and deserialises returned bytes.
  assumes cmd_* stay stable while cmd_vld is high.
*/
`timescale 1ns/1ps
`default_nettype none
module dlp_host
  import dlp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // link
  dlp_link_if.host         lnk,
  // command request
  input  wire logic        cmd_vld,
  output logic             cmd_rdy,
  input  wire logic [7:0]  cmd_id,
  input  wire logic [15:0] cmd_word,
  // payload bytes
  input  wire logic        pay_vld,
  output logic             pay_rdy,
  input  wire logic [7:0]  pay_data,
  // returned bytes
  output logic             rb_vld,
  output logic [7:0]       rb_data
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_TAKE = 3'b001,
    H_HDR  = 3'b011,
    H_PAY  = 3'b010,
    H_FTR  = 3'b110
  } dlp_hst_t;

  typedef struct packed {
    dlp_hst_t    hs;
    logic        cmd_rdy;
    logic        frm;
    logic        vld;
    logic        bt;
    logic        tok;
    logic [2:0]  tb;
    logic [7:0]  tcur;
    logic [15:0] ti;
    logic [31:0] th;
    logic        tlong;
    logic [15:0] tn;
    logic [15:0] crc;
    logic        resp;
    logic [2:0]  rb;
    logic [7:0]  rsh;
    logic        rb_vld;
  } dlp_host_st_t;

  dlp_host_st_t s_r;
  dlp_host_st_t s_nxt;
  logic         fvld;
  logic         fpop;
  logic [7:0]   fdat;
  logic [23:0]  h;

  dlp_fifo2 u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .in_vld   (pay_vld),
    .in_rdy   (pay_rdy),
    .in_data  (pay_data),
    .out_vld  (fvld),
    .out_rdy  (fpop),
    .out_data (fdat)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    fpop = 1'b0;
    h = {cmd_word, cmd_id};
    s_nxt.vld = 1'b0;
    s_nxt.rb_vld = 1'b0;
    if (s_r.tok) begin
      s_nxt.vld = 1'b1;
      s_nxt.bt = s_r.tcur[s_r.tb];
      s_nxt.tb = s_r.tb + 3'h1;
      if (s_r.tb == 3'h7) s_nxt.tok = 1'b0;
    end else begin
      unique case (s_r.hs)
        H_IDLE: begin
          if (!cmd_vld) begin
            s_nxt.frm = 1'b0;
            s_nxt.resp = 1'b0;
          end else if (s_r.frm && s_r.resp && dlp_needs_resp(cmd_id[5:0])) begin
            // second read forces a new transmission
            s_nxt.frm = 1'b0;
            s_nxt.resp = 1'b0;
          end else begin
            s_nxt.cmd_rdy = 1'b1;
            s_nxt.hs = H_TAKE;
          end
        end
        H_TAKE: begin
          s_nxt.cmd_rdy = 1'b0;
          s_nxt.th = {dlp_ecc(h), h};
          s_nxt.tlong = dlp_is_long(cmd_id[5:0]);
          s_nxt.tn = cmd_word;
          s_nxt.crc = DLP_CRC_SEED;
          s_nxt.resp = s_r.resp | dlp_needs_resp(cmd_id[5:0]);
          s_nxt.frm = 1'b1;
          s_nxt.ti = 16'h0;
          s_nxt.hs = H_HDR;
        end
        H_HDR: begin
          s_nxt.tcur = s_r.th[7:0];
          s_nxt.th = s_r.th >> 8;
          s_nxt.tok = 1'b1;
          s_nxt.ti = s_r.ti + 16'h1;
          if (s_r.ti == 16'(DLP_HDR_BYTES - 1)) begin
            s_nxt.ti = 16'h0;
            if (!s_r.tlong) s_nxt.hs = H_IDLE;
            else if (s_r.tn == 16'h0) s_nxt.hs = H_FTR;
            else s_nxt.hs = H_PAY;
          end
        end
        H_PAY: begin
          if (fvld) begin
            fpop = 1'b1;
            s_nxt.tcur = fdat;
            s_nxt.crc = dlp_crc(s_r.crc, fdat);
            s_nxt.tok = 1'b1;
            s_nxt.ti = s_r.ti + 16'h1;
            if (s_r.ti == s_r.tn - 16'h1) begin
              s_nxt.ti = 16'h0;
              s_nxt.hs = H_FTR;
            end
          end
        end
        H_FTR: begin
          s_nxt.tcur = (s_r.ti == 16'h0) ? s_r.crc[7:0] : s_r.crc[15:8];
          s_nxt.tok = 1'b1;
          s_nxt.ti = s_r.ti + 16'h1;
          if (s_r.ti == 16'(DLP_FTR_BYTES - 1)) s_nxt.hs = H_IDLE;
        end
        default: s_nxt.hs = H_IDLE;
      endcase
    end
    // returning bytes, lsb first
    if (!lnk.r_frm) begin
      s_nxt.rb = 3'h0;
    end else if (lnk.r_vld) begin
      s_nxt.rsh = {lnk.r_bit, s_r.rsh[7:1]};
      s_nxt.rb = s_r.rb + 3'h1;
      s_nxt.rb_vld = (s_r.rb == 3'h7);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign lnk.f_frm = s_r.frm;
  assign lnk.f_vld = s_r.vld;
  assign lnk.f_bit = s_r.bt;
  assign cmd_rdy   = s_r.cmd_rdy;
  assign rb_vld    = s_r.rb_vld;
  assign rb_data   = s_r.rsh;

endmodule
`default_nettype wire

//--- testbench/dlp_link_chk.sv
/*
  link checker: framing, byte gaps, header bits.
  assumes one clock; TAG is the peripheral's tag.
*/
`timescale 1ns/1ps
`default_nettype none
module dlp_link_chk #(
  parameter logic [1:0] TAG = 2'b00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // forward
  input wire logic f_frm,
  input wire logic f_vld,
  input wire logic f_bit,
  // reverse
  input wire logic r_frm,
  input wire logic r_vld,
  input wire logic r_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // header checks see only a frame's first packet
  logic [15:0] fc_r;
  logic [15:0] rc_r;
  logic [7:0]  fs_r;
  logic [7:0]  rs_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fc_r <= 16'h0000;
      rc_r <= 16'h0000;
      fs_r <= 8'h00;
      rs_r <= 8'h00;
    end else begin
      fc_r <= f_frm ? fc_r + {15'h0000, f_vld} : 16'h0000;
      rc_r <= r_frm ? rc_r + {15'h0000, r_vld} : 16'h0000;
      if (f_vld) fs_r <= {f_bit, fs_r[7:1]};
      if (r_vld) rs_r <= {r_bit, rs_r[7:1]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_fvld_in_frm: assert property (f_vld |-> f_frm) else $error("f_vld off frame");
  a_rvld_in_frm: assert property (r_vld |-> r_frm) else $error("r_vld off frame");
  a_fwd_whole_bytes: assert property ($fell(f_frm) |-> fc_r[2:0] == 3'h0) else $error("f part byte");
  a_rev_whole_bytes: assert property ($fell(r_frm) |-> rc_r[2:0] == 3'h0) else $error("r part byte");
  a_fwd_byte_gap: assert property (f_vld && fc_r[2:0] == 3'h7 |=> !f_vld) else $error("f gap");
  a_rev_byte_gap: assert property (r_vld && rc_r[2:0] == 3'h7 |=> !r_vld) else $error("r gap");
  a_fwd_lead_gap: assert property ($rose(f_frm) |-> !f_vld) else $error("f lead bit");
  a_fwd_ecc_top: assert property (f_vld && fc_r == 16'd31 |=> fs_r[7:6] == 2'b00) else $error("f ecc top");
  a_rev_ecc_top: assert property (r_vld && rc_r == 16'd31 |=> rs_r[7:6] == 2'b00) else $error("r ecc top");
  a_rev_own_tag: assert property (r_vld && rc_r == 16'd7 |=> rs_r[7:6] == TAG) else $error("r tag");
endmodule
`default_nettype wire

//--- testbench/test_display_link_packet_layer.sv
/*
  bench: host and peripheral on one link; a second peripheral takes raw headers.
  assumes one clock; results are queued ahead.
*/
`timescale 1ns/1ps
`default_nettype none
module test_display_link_packet_layer;
  localparam logic [1:0] MY = 2'b10;
  logic clk = 0, rstn = 0, cmd_vld = 0, pay_vld = 0, tq_vld = 0, tp_vld = 0, fp = 0, z = 0;
  logic [1:0] tg = MY;
  logic cmd_rdy, pay_rdy, rb_vld, hd_vld, hd_corr, hd_bad, pd_vld, pd_last, ck_vld, ck_bad, tq_rdy, tp_rdy;
  logic h2_vld, h2_corr, h2_bad;
  logic [7:0] cmd_id = 0, pay_data = 0, tp_data = 0, rb_data, hd_id, pd_data, h2_id, fsh;
  logic [15:0] cmd_word = 0, tq_word = 0, hd_word, h2_word;
  logic [5:0] tq_type = 0;
  logic [31:0] rs = 32'ha5f9231f;
  logic [26:0] qh[$], q2[$];
  logic [8:0] qp[$], qr[$], qw[$];
  logic qc[$];
  int error_cnt = 0, n_checks = 0, cyc = 0, frames = 0, fn = 0;
  dlp_link_if lnk ();
  dlp_link_if lnk2 ();
  dlp_host dlp_host_i (.clk, .rstn, .lnk(lnk), .cmd_vld, .cmd_rdy, .cmd_id, .cmd_word, .pay_vld, .pay_rdy,
    .pay_data, .rb_vld, .rb_data);
  dlp_periph dlp_periph_i (.clk, .rstn, .lnk(lnk), .my_tag(tg), .hd_vld, .hd_id, .hd_word, .hd_corr, .hd_bad,
    .pd_vld, .pd_data, .pd_last, .ck_vld, .ck_bad, .tq_vld, .tq_rdy, .tq_type, .tq_word, .tp_vld, .tp_rdy, .tp_data);
  dlp_periph dlp_periph_i2 (.clk, .rstn, .lnk(lnk2), .my_tag(tg), .hd_vld(h2_vld), .hd_id(h2_id), .hd_word(h2_word),
    .hd_corr(h2_corr), .hd_bad(h2_bad), .pd_vld(), .pd_data(), .pd_last(), .ck_vld(), .ck_bad(), .tq_vld(z),
    .tq_rdy(), .tq_type, .tq_word, .tp_vld(z), .tp_rdy(), .tp_data);
  dlp_link_chk #(.TAG(MY)) dlp_link_chk_i (.clk, .rstn, .f_frm(lnk.f_frm), .f_vld(lnk.f_vld), .f_bit(lnk.f_bit),
    .r_frm(lnk.r_frm), .r_vld(lnk.r_vld), .r_bit(lnk.r_bit));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function logic [7:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[7:0];
  endfunction
  // own header code
  function automatic logic [7:0] ecc_of(input logic [23:0] h);
    logic [4:0] p;
    int k;
    p = 5'h00;
    k = 0;
    for (int v = 3; v < 32; v++) if ((v & (v - 1)) != 0) begin
      if (k < 24 && h[k]) p ^= 5'(v);
      k++;
    end
    return {2'b00, ^{h, p}, p};
  endfunction
  task bad(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task send_cmd(input logic [7:0] id, input logic [15:0] w);
    logic [7:0] b;
    logic mine;
    mine = id[7:6] == MY;
    @(negedge clk);
    cmd_vld = 1;
    cmd_id = id;
    cmd_word = w;
    qw.push_back({1'b1, id});
    qw.push_back({1'b1, w[7:0]});
    qw.push_back({1'b1, w[15:8]});
    qw.push_back({1'b1, ecc_of({w, id})});
    if (mine) qh.push_back({id, w, 2'b00});
    while (cmd_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_vld = 0;
    if (id[3:0] >= 4'h9 && id[3:0] <= 4'he) begin
      // buffer stalls the feed
      for (int i = 0; i < w; i++) begin
        b = rnd();
        pay_vld = 1;
        pay_data = b;
        qw.push_back({1'b1, b});
        if (mine) qp.push_back({b, i == w - 1});
        while (pay_rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
      end
      pay_vld = 0;
      qw.push_back({w == 16'h0000, 8'hff});
      qw.push_back({w == 16'h0000, 8'hff});
      if (mine) qc.push_back(1'b0);
    end
  endtask
  task send_ret(input logic [5:0] t, input logic [15:0] w);
    logic [7:0] b;
    @(negedge clk);
    tq_vld = 1;
    tq_type = t;
    tq_word = w;
    qr.push_back({1'b1, MY, t});
    qr.push_back({1'b1, w[7:0]});
    qr.push_back({1'b1, w[15:8]});
    qr.push_back({1'b1, ecc_of({w, MY, t})});
    while (tq_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    tq_vld = 0;
    if (t[3:0] >= 4'h9 && t[3:0] <= 4'he) begin
      for (int i = 0; i < w; i++) begin
        b = rnd();
        tp_vld = 1;
        tp_data = b;
        qr.push_back({1'b1, b});
        while (tp_rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
      end
      tp_vld = 0;
      qr.push_back(9'h100);
      qr.push_back(9'h100);
    end
  endtask
  task send_raw(input logic [23:0] h, input logic [31:0] m, input logic [26:0] e);
    logic [31:0] w;
    w = {ecc_of(h), h} ^ m;
    q2.push_back(e);
    @(negedge clk);
    lnk2.f_frm = 1;
    for (int i = 0; i < 32; i++) begin
      if (i % 8 == 0) begin
        @(negedge clk);
        lnk2.f_vld = 0;
        lnk2.f_bit = ~lnk2.f_bit;
      end
      @(negedge clk);
      lnk2.f_vld = 1;
      lnk2.f_bit = w[i];
    end
    @(negedge clk);
    lnk2.f_vld = 0;
    lnk2.f_bit = ~lnk2.f_bit;
    @(negedge clk);
    lnk2.f_frm = 0;
  endtask
  task wait_idle();
    int k;
    k = 0;
    while (k < 12) begin
      @(negedge clk);
      k = (lnk.f_frm || lnk.r_frm) ? 0 : k + 1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    logic [8:0] e9;
    logic [26:0] e;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
    if (hd_vld) begin
      n_checks++;
      if (qh.size() == 0 || {hd_id, hd_word, hd_corr, hd_bad} !== qh.pop_front()) bad("header");
    end
    if (pd_vld) begin
      n_checks++;
      if (qp.size() == 0 || {pd_data, pd_last} !== qp.pop_front()) bad("payload");
    end
    if (ck_vld) begin
      n_checks++;
      if (qc.size() == 0 || ck_bad !== qc.pop_front()) bad("footer");
    end
    if (rb_vld) begin
      n_checks++;
      if (qr.size() == 0) bad("return extra");
      else begin
        e9 = qr.pop_front();
        if (e9[8] && rb_data !== e9[7:0]) bad("return byte");
      end
    end
    if (h2_vld) begin
      n_checks++;
      if (q2.size() == 0) bad("raw extra");
      else begin
        e = q2.pop_front();
        if (e[0] ? h2_bad !== 1'b1 : {h2_id, h2_word, h2_corr, h2_bad} !== e) bad("raw header");
      end
    end
    if (!lnk.f_frm) fn = 0;
    else if (lnk.f_vld) begin
      fsh = {lnk.f_bit, fsh[7:1]};
      fn++;
      if (fn == 8) begin
        fn = 0;
        n_checks++;
        if (qw.size() == 0) bad("wire extra");
        else begin
          e9 = qw.pop_front();
          if (e9[8] && fsh !== e9[7:0]) bad("wire byte");
        end
      end
    end
    if (lnk.f_frm && !fp) frames++;
    fp = lnk.f_frm;
  end
  initial begin
    int f0;
    lnk2.f_frm = 0;
    lnk2.f_vld = 0;
    lnk2.f_bit = 0;
    repeat (20) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    send_cmd({MY, 6'h23}, {rnd(), rnd()});
    send_cmd({2'b01, 6'h29}, 16'h0003);
    send_cmd({MY, 6'h29}, 16'h0005);
    send_cmd({MY, 6'h19}, 16'h0000);
    for (int t = 0; t < 4; t++) send_cmd({2'(t), 6'h15}, {rnd(), rnd()});
    wait_idle();
    f0 = frames;
    send_cmd({MY, 6'h04}, 16'h0000);
    send_cmd({2'b00, 6'h03}, 16'h0000);
    send_cmd({MY, 6'h14}, {8'h00, rnd()});
    wait_idle();
    n_checks++;
    if (frames != f0 + 2) bad("two reads in a frame");
    send_ret(6'h21, {rnd(), rnd()});
    wait_idle();
    send_ret(6'h1a, 16'h0003);
    wait_idle();
    send_raw({16'h5a3c, MY, 6'h05}, 32'h0000_0008, {MY, 6'h05, 16'h5a3c, 2'b10});
    send_raw({16'h5a3c, MY, 6'h05}, 32'h0000_1008, 27'h0000001);
    repeat (60) @(negedge clk);
    n_checks++;
    if (qh.size() + qp.size() + qc.size() + qr.size() + qw.size() + q2.size() != 0) bad("results missing");
    print_verdict();
  end
endmodule
`default_nettype wire
